/* File: rtl/rgeseq_params.svh */
/*
  Constants of the graphic order sequencer: opcode field, word layout, reset values.
  Assumes one 50 MHz clock and a memory port that answers one 32-bit word per request.
*/
`ifndef RGESEQ_PARAMS_SVH
`define RGESEQ_PARAMS_SVH

// order word: [31:26] opcode, [25:0] immediate field
`define RGESEQ_OP_MSB 31
`define RGESEQ_OP_LSB 26
`define RGESEQ_IMM_MSB 25
`define RGESEQ_IMM_LSB 0
`define RGESEQ_ADDR_W 32
`define RGESEQ_ADDR_STEP 32'h0000_0004
`define RGESEQ_CODE_W 8
`define RGESEQ_CODE_RST 8'h00
// expanded transfer immediate: [3:0] x factor minus one, [7:4] y factor minus one
`define RGESEQ_XF_LSB 0
`define RGESEQ_YF_LSB 4
// run word from the run table: [15:0] run length, zero terminates the table
`define RGESEQ_RUN_MSB 15
`define RGESEQ_RUN_END 16'h0000

`endif

/* File: rtl/rgeseq_pkg.sv */
/*
  Types of the graphic order sequencer.
  Assumes rgeseq_params.svh is on the include path.
*/
package rgeseq_pkg;
  typedef enum logic [5:0] {
    RGESEQ_SET_BANDED    = 6'h01,
    RGESEQ_SET_UNBANDED  = 6'h02,
    RGESEQ_SET_SOURCE    = 6'h03,
    RGESEQ_SET_HALFTONE  = 6'h04,
    RGESEQ_LOAD_D        = 6'h05,
    RGESEQ_LOAD_HD       = 6'h06,
    RGESEQ_LOAD_SD       = 6'h07,
    RGESEQ_LOAD_SHD      = 6'h08,
    RGESEQ_JUMP          = 6'h09,
    RGESEQ_STOP          = 6'h0A,
    RGESEQ_RECT_F_D      = 6'h10,
    RGESEQ_RECT_F_SD     = 6'h11,
    RGESEQ_RECT_F_SHD    = 6'h12,
    RGESEQ_RECT_U_D      = 6'h13,
    RGESEQ_RECT_U_SD     = 6'h14,
    RGESEQ_RECT_U_SHD    = 6'h15,
    RGESEQ_RECT_B_D      = 6'h16,
    RGESEQ_RECT_B_SD     = 6'h17,
    RGESEQ_RECT_B_SHD    = 6'h18,
    RGESEQ_EXP_F_D       = 6'h20,
    RGESEQ_EXP_F_HD      = 6'h21,
    RGESEQ_EXP_U_D       = 6'h22,
    RGESEQ_EXP_U_HD      = 6'h23,
    RGESEQ_EXP_B_D       = 6'h24,
    RGESEQ_EXP_B_HD      = 6'h25,
    RGESEQ_RUNS_F_D      = 6'h30,
    RGESEQ_RUNS_F_HD     = 6'h31,
    RGESEQ_RUNS_U_D      = 6'h32,
    RGESEQ_RUNS_U_HD     = 6'h33,
    RGESEQ_RUNS_B_D      = 6'h34,
    RGESEQ_RUNS_B_HD     = 6'h35
  } rgeseq_op_e;

  // kind of transfer handed to the pixel engine
  typedef enum logic [1:0] {
    RGESEQ_K_RECT = 2'h0,
    RGESEQ_K_EXP  = 2'h1,
    RGESEQ_K_RUN  = 2'h2
  } rgeseq_kind_e;

  // which parameter set an order loads (one-hot over four bitmaps)
  typedef logic [3:0] rgeseq_bmsel_t;
endpackage

/* File: rtl/rgeseq_top.sv */
/*
  Graphic order sequencer: fetches orders from the display list, keeps bitmap
  parameters and the four combining codes, walks run tables and hands each
  transfer to the pixel engine through a two-entry buffer.
  Assumes a word memory that answers i_mem_valid some cycles after o_mem_req,
  and a pixel engine that takes a job when o_job_valid and i_job_ready are high.
*/
`include "rgeseq_params.svh"

module rgeseq_top
  import rgeseq_pkg::*;
(
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  // control
  input wire logic I_START,
  input wire logic [31:0] I_LIST_ADDR,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_BAD_ORDER,
  // memory read port
  output logic O_MEM_REQ,
  output logic [31:0] O_MEM_ADDR,
  input wire logic I_MEM_VALID,
  input wire logic [31:0] I_MEM_DATA,
  // job port towards the pixel engine
  output logic O_JOB_VALID,
  input wire logic I_JOB_READY,
  output logic [1:0] O_JOB_KIND,
  output logic [2:0] O_JOB_DEST,
  output logic [7:0] O_JOB_CODE,
  output logic [31:0] O_JOB_ARG,
  output logic [4:0] O_JOB_XF,
  output logic [4:0] O_JOB_YF,
  // parameters held for the pixel engine
  output logic [31:0] O_BM_BANDED,
  output logic [31:0] O_BM_UNBANDED,
  output logic [31:0] O_BM_SOURCE,
  output logic [31:0] O_BM_HALFTONE
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_ARG, ST_EXEC, ST_RUNREQ, ST_RUNWAIT, ST_PUSH
  } rgeseq_st_e;

  rgeseq_st_e st_ff;
  logic [31:0] pc_ff;
  logic [31:0] run_ptr_ff;
  logic [31:0] order_ff;
  logic [31:0] arg_ff;
  logic [7:0] code_d_ff, code_sd_ff, code_hd_ff, code_shd_ff;
  logic [31:0] bm_ff [4];
  logic done_ff, bad_ff, req_ff, busy_ff;
  logic [31:0] req_addr_ff;

  // job word pushed into the buffer
  localparam int JW = 2 + 3 + 8 + 32 + 5 + 5;
  logic push_valid;
  logic push_ready;
  logic [JW-1:0] push_data;
  logic [JW-1:0] out_q_ff, skid_q_ff;
  logic out_vld_ff, skid_vld_ff;

  rgeseq_op_e op;
  logic [3:0] xf_m1, yf_m1;
  logic xf_ok;
  logic is_rect, is_exp, is_run, has_arg;
  logic [7:0] sel_code;
  logic [2:0] dest_sel;

  assign op = rgeseq_op_e'(order_ff[`RGESEQ_OP_MSB:`RGESEQ_OP_LSB]);
  assign xf_m1 = order_ff[`RGESEQ_XF_LSB +: 4];
  assign yf_m1 = order_ff[`RGESEQ_YF_LSB +: 4];
  assign is_rect = (order_ff[31:30] == 2'h1);
  assign is_exp = (order_ff[31:29] == 3'h4);
  assign is_run = (order_ff[31:29] == 3'h6);
  assign has_arg = is_exp || is_run || (op == RGESEQ_JUMP);
  // x factor 1,2,3,4,6,8,12,16 only (minus one: 0,1,2,3,5,7,11,15)
  assign xf_ok = (xf_m1 <= 4'h3) || (xf_m1 == 4'h5) || (xf_m1 == 4'h7)
                 || (xf_m1 == 4'hB) || (xf_m1 == 4'hF);

  ////////////////////////////////////////////////////////////////////////
  // code selection and destination decode
  always_comb begin
    sel_code = code_d_ff;
    dest_sel = 3'h0;
    if (is_rect) begin
      // rect: d, sd, shd only
      unique case (order_ff[29:26] % 4'h3)
        4'h0: sel_code = code_d_ff;
        4'h1: sel_code = code_sd_ff;
        default: sel_code = code_shd_ff;
      endcase
      dest_sel = 3'(order_ff[29:26] / 4'h3);
    end else if (is_exp) begin
      // expanded: sd or shd
      sel_code = order_ff[26] ? code_shd_ff : code_sd_ff;
      dest_sel = 3'(order_ff[28:27]);
    end else if (is_run) begin
      // runs: d or hd only
      sel_code = order_ff[26] ? code_hd_ff : code_d_ff;
      dest_sel = 3'(order_ff[28:27]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // order sequencing
  assign push_ready = !skid_vld_ff;
  always_comb begin
    push_valid = 1'b0;
    push_data = '0;
    if (st_ff == ST_PUSH) begin
      push_valid = 1'b1;
      if (is_run) begin
        // each run carries its length; clip and pitch ride in arg for expanded jobs, the order immediate for rects
        push_data = {RGESEQ_K_RUN, dest_sel, sel_code, arg_ff, 5'h01, 5'h01};
      end else if (is_exp) begin
        // pitch and clip window word; both axes expanded in one job
        push_data = {RGESEQ_K_EXP, dest_sel, sel_code, arg_ff,
                     5'(xf_m1) + 5'h01, 5'(yf_m1) + 5'h01};
      end else begin
        push_data = {RGESEQ_K_RECT, dest_sel, sel_code,
                     {6'h00, order_ff[25:0]}, 5'h01, 5'h01};
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_ff <= ST_IDLE;
      pc_ff <= 32'h0000_0000;
      run_ptr_ff <= 32'h0000_0000;
      order_ff <= 32'h0000_0000;
      arg_ff <= 32'h0000_0000;
      req_ff <= 1'b0;
      req_addr_ff <= 32'h0000_0000;
      done_ff <= 1'b0;
      bad_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      req_ff <= 1'b0;
      unique case (st_ff)
        ST_IDLE: begin
          // only a new start with a list address leaves idle
          if (I_START) begin
            pc_ff <= I_LIST_ADDR;
            req_addr_ff <= I_LIST_ADDR;
            req_ff <= 1'b1;
            done_ff <= 1'b0;
            bad_ff <= 1'b0;
            busy_ff <= 1'b1;
            st_ff <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (I_MEM_VALID) begin
            order_ff <= I_MEM_DATA;
            pc_ff <= pc_ff + `RGESEQ_ADDR_STEP;
            st_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (has_arg) begin
            req_addr_ff <= pc_ff;
            req_ff <= 1'b1;
            st_ff <= ST_ARG;
          end else if (op == RGESEQ_STOP) begin
            done_ff <= 1'b1;
            busy_ff <= 1'b0;
            st_ff <= ST_IDLE;
          end else if (is_rect) begin
            st_ff <= ST_PUSH;
          end else begin
            req_addr_ff <= pc_ff;
            req_ff <= 1'b1;
            st_ff <= ST_FETCH;
          end
        end
        ST_ARG: begin
          if (I_MEM_VALID) begin
            arg_ff <= I_MEM_DATA;
            pc_ff <= pc_ff + `RGESEQ_ADDR_STEP;
            if (op == RGESEQ_JUMP) begin
              pc_ff <= I_MEM_DATA;
              req_addr_ff <= I_MEM_DATA;
              req_ff <= 1'b1;
              st_ff <= ST_FETCH;
            end else if (is_run) begin
              run_ptr_ff <= I_MEM_DATA;
              st_ff <= ST_RUNREQ;
            end else if (is_exp && !xf_ok) begin
              // illegal x factor: the order is dropped and flagged
              bad_ff <= 1'b1;
              req_addr_ff <= pc_ff + `RGESEQ_ADDR_STEP;
              req_ff <= 1'b1;
              st_ff <= ST_FETCH;
            end else begin
              st_ff <= ST_PUSH;
            end
          end
        end
        ST_RUNREQ: begin
          req_addr_ff <= run_ptr_ff;
          req_ff <= 1'b1;
          st_ff <= ST_RUNWAIT;
        end
        ST_RUNWAIT: begin
          if (I_MEM_VALID) begin
            run_ptr_ff <= run_ptr_ff + `RGESEQ_ADDR_STEP;
            if (I_MEM_DATA[`RGESEQ_RUN_MSB:0] == `RGESEQ_RUN_END) begin
              // table exhausted: only now the list resumes
              req_addr_ff <= pc_ff;
              req_ff <= 1'b1;
              st_ff <= ST_FETCH;
            end else begin
              arg_ff <= I_MEM_DATA;
              st_ff <= ST_PUSH;
            end
          end
        end
        ST_PUSH: begin
          if (push_ready) begin
            if (is_run) begin
              st_ff <= ST_RUNREQ;
            end else begin
              req_addr_ff <= pc_ff;
              req_ff <= 1'b1;
              st_ff <= ST_FETCH;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parameter and code registers
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      code_d_ff <= `RGESEQ_CODE_RST;
      code_sd_ff <= `RGESEQ_CODE_RST;
      code_hd_ff <= `RGESEQ_CODE_RST;
      code_shd_ff <= `RGESEQ_CODE_RST;
    end else if (st_ff == ST_EXEC) begin
      // each code only by its own load order
      if (op == RGESEQ_LOAD_D) code_d_ff <= order_ff[7:0];
      if (op == RGESEQ_LOAD_SD) code_sd_ff <= order_ff[7:0];
      if (op == RGESEQ_LOAD_HD) code_hd_ff <= order_ff[7:0];
      if (op == RGESEQ_LOAD_SHD) code_shd_ff <= order_ff[7:0];
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_bm
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        bm_ff[g] <= 32'h0000_0000;
      end else if (st_ff == ST_EXEC && op == rgeseq_op_e'(6'(g + 1))) begin
        bm_ff[g] <= {6'h00, order_ff[25:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry job buffer: output word plus skid word; a full skid holds ST_PUSH
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      out_vld_ff <= 1'b0;
      skid_vld_ff <= 1'b0;
      out_q_ff <= '0;
      skid_q_ff <= '0;
    end else if (!out_vld_ff || I_JOB_READY) begin
      // output slot frees: the older skid word goes first to keep order
      out_vld_ff <= skid_vld_ff || push_valid;
      out_q_ff <= skid_vld_ff ? skid_q_ff : push_data;
      skid_vld_ff <= 1'b0;
    end else if (push_valid && push_ready) begin
      skid_vld_ff <= 1'b1;
      skid_q_ff <= push_data;
    end
  end
  assign O_JOB_VALID = out_vld_ff;
  assign {O_JOB_KIND, O_JOB_DEST, O_JOB_CODE, O_JOB_ARG, O_JOB_XF, O_JOB_YF} = out_q_ff;
  assign O_BUSY = busy_ff;
  assign O_DONE = done_ff;
  assign O_BAD_ORDER = bad_ff;
  assign O_MEM_REQ = req_ff;
  assign O_MEM_ADDR = req_addr_ff;
  assign O_BM_BANDED = bm_ff[0];
  assign O_BM_UNBANDED = bm_ff[1];
  assign O_BM_SOURCE = bm_ff[2];
  assign O_BM_HALFTONE = bm_ff[3];

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_stop_idle;
    @(posedge I_CLOCK) disable iff (!I_RESET_N)
    (st_ff == ST_EXEC && op == RGESEQ_STOP) |=> (st_ff == ST_IDLE) && O_DONE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

  property p_idle_quiet;
    @(posedge I_CLOCK) disable iff (!I_RESET_N)
    (st_ff == ST_IDLE && !I_START) |=> !O_MEM_REQ;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("fetch while idle");

  property p_jump;
    @(posedge I_CLOCK) disable iff (!I_RESET_N)
    (st_ff == ST_ARG && op == RGESEQ_JUMP && I_MEM_VALID)
      |=> O_MEM_REQ && O_MEM_ADDR == $past(I_MEM_DATA);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_code_d;
    @(posedge I_CLOCK) disable iff (!I_RESET_N)
    (st_ff == ST_EXEC && op != RGESEQ_LOAD_D) |=> $stable(code_d_ff);
  endproperty
  a_code_d: assert property (p_code_d) else $error("code written by other order");

  property p_run_code;
    @(posedge I_CLOCK) disable iff (!I_RESET_N)
    (push_valid && is_run) |-> (sel_code == code_d_ff || sel_code == code_hd_ff);
  endproperty
  a_run_code: assert property (p_run_code) else $error("bad run code");

  property p_run_done;
    @(posedge I_CLOCK) disable iff (!I_RESET_N)
    (st_ff == ST_RUNWAIT && I_MEM_VALID && I_MEM_DATA[15:0] != 16'h0000)
      |=> st_ff == ST_PUSH;
  endproperty
  a_run_done: assert property (p_run_done) else $error("table left early");

  property p_xf;
    @(posedge I_CLOCK) disable iff (!I_RESET_N)
    (push_valid && is_exp) |-> xf_ok && push_data[9:5] != 5'h00;
  endproperty
  a_xf: assert property (p_xf) else $error("illegal x factor issued");

  property p_buf;
    @(posedge I_CLOCK) disable iff (!I_RESET_N)
    (skid_vld_ff && !I_JOB_READY) |=> skid_vld_ff && $stable(O_JOB_ARG);
  endproperty
  a_buf: assert property (p_buf) else $error("job lost under stall");

endmodule // rgeseq_top

/* File: verif/rgeseq_mem_model.sv */
/*
  Word memory standing in for the display list store of the order sequencer.
  Assumes the bench fills mem and sets i_lat between runs; one read at a time.
*/
module rgeseq_mem_model (
  // clock
  input wire logic i_clk,
  // read port
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_lat,
  output logic o_valid,
  output logic [31:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic pend = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [7:0] idx = 8'h00;
  initial o_valid = 1'b0;
  initial o_data = 32'h0000_0000;
  ////////////////////////////////////////////////////////////////////////////
  // answer i_lat+1 cycles after the request; between answers the data lines keep toggling
  always @(negedge i_clk) begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (i_req) begin
      pend <= 1'b1;
      cnt <= i_lat;
      idx <= i_addr[9:2];
    end else if (pend && cnt == 4'h0) begin
      pend <= 1'b0;
      o_valid <= 1'b1;
      o_data <= mem[idx];
    end else if (pend) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule // rgeseq_mem_model

/* File: verif/test_graphic_order_sequencer.sv */
/*
  Self-checking bench of the order sequencer: builds display lists in the
  memory model, runs them and compares the jobs handed to the pixel engine.
  Assumes rgeseq_pkg is compiled first and rgeseq_params.svh is on the path.
*/
module test_graphic_order_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import rgeseq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [31:0] list_addr = 32'h0000_0000;
  logic busy, done, bad, mem_req, mem_valid, job_valid;
  logic [31:0] mem_addr, mem_data, job_arg, bm_b, bm_u, bm_s, bm_h;
  logic [1:0] job_kind;
  logic [2:0] job_dest;
  logic [7:0] job_code;
  logic [4:0] job_xf, job_yf;
  logic job_ready = 1'b0;
  logic stall = 1'b0;
  logic [3:0] lat = 4'h0;
  int cyc = 0;
  int reqn = 0;
  int pc;
  int err_total = 0;
  int cmp_count = 0;
  logic [54:0] got[$];
  logic [54:0] expq[$];
  logic [54:0] mskq[$];
  localparam logic [54:0] M_RECT = {13'h1FFF, 42'h0};
  localparam logic [54:0] M_EXP = {55{1'b1}};
  localparam logic [54:0] M_RUN = {13'h1FFF, 26'h0, 16'hFFFF};
  always #10 clk = ~clk;
  rgeseq_top i_dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_START(start),
    .I_LIST_ADDR(list_addr), .O_BUSY(busy), .O_DONE(done), .O_BAD_ORDER(bad),
    .O_MEM_REQ(mem_req), .O_MEM_ADDR(mem_addr), .I_MEM_VALID(mem_valid),
    .I_MEM_DATA(mem_data), .O_JOB_VALID(job_valid), .I_JOB_READY(job_ready),
    .O_JOB_KIND(job_kind), .O_JOB_DEST(job_dest), .O_JOB_CODE(job_code),
    .O_JOB_ARG(job_arg), .O_JOB_XF(job_xf), .O_JOB_YF(job_yf),
    .O_BM_BANDED(bm_b), .O_BM_UNBANDED(bm_u), .O_BM_SOURCE(bm_s),
    .O_BM_HALFTONE(bm_h));
  rgeseq_mem_model i_mem (.i_clk(clk), .i_req(mem_req), .i_addr(mem_addr),
    .i_lat(lat), .o_valid(mem_valid), .o_data(mem_data));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (job_valid && job_ready) begin
      got.push_back({job_kind, job_dest, job_code, job_xf, job_yf, job_arg});
    end
    if (mem_req) begin
      reqn++;
    end
  end
  // stalled engine is ready one cycle in eight so the buffer fills and refuses
  always @(negedge clk) begin
    cyc <= cyc + 1;
    job_ready <= !stall || (cyc % 8 == 0);
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] ow(input logic [5:0] op, input logic [25:0] imm);
    return {op, imm};
  endfunction
  task automatic put(input logic [31:0] w);
    i_mem.mem[pc[9:2]] = w;
    pc += 4;
  endtask
  task automatic want(input logic [1:0] k, input logic [2:0] d, input logic [7:0] c,
                      input logic [4:0] x, input logic [4:0] y, input logic [31:0] a,
                      input logic [54:0] m);
    expq.push_back({k, d, c, x, y, a} & m);
    mskq.push_back(m);
  endtask
  task automatic run(input logic [31:0] base);
    int n;
    got.delete();
    @(negedge clk);
    list_addr = base;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (job_valid !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
  endtask
  task automatic judge(input string name);
    check("done", done, 1'b1);
    check("job count", got.size(), expq.size());
    foreach (expq[i]) begin
      if (i < got.size()) begin
        check("job", got[i] & mskq[i], expq[i]);
      end
    end
    expq.delete();
    mskq.delete();
    $display("test %s done", name);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_rect();
    logic [7:0] rc [3] = '{8'h5A, 8'h96, 8'h3C};
    lat = 4'h3;
    stall = 1'b1;
    pc = 32'h100;
    put(ow(RGESEQ_SET_BANDED, 26'h0000B01));
    put(ow(RGESEQ_SET_UNBANDED, 26'h2000B02));
    put(ow(RGESEQ_SET_SOURCE, 26'h1234567));
    put(ow(RGESEQ_SET_HALFTONE, 26'h3FFFFFF));
    put(ow(RGESEQ_LOAD_D, 26'h5A));
    put(ow(RGESEQ_LOAD_HD, 26'hC3));
    put(ow(RGESEQ_LOAD_SD, 26'h96));
    put(ow(RGESEQ_LOAD_SHD, 26'h3C));
    for (int i = 0; i < 9; i++) begin
      put(ow(6'h10 + i[5:0], 26'h0));
      want(RGESEQ_K_RECT, i / 3, rc[i % 3], 5'h00, 5'h00, 32'h0, M_RECT);
    end
    put(ow(RGESEQ_STOP, 26'h0));
    run(32'h100);
    check("bitmaps", {bm_b, bm_u}, 64'h0000_0B01_0200_0B02);
    check("bitmaps", {bm_s, bm_h}, 64'h0123_4567_03FF_FFFF);
    judge("rect");
  endtask
  task automatic t_exp();
    logic [4:0] xl [8] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd6, 5'd8, 5'd12, 5'd16};
    logic [4:0] y;
    lat = 4'h0;
    stall = 1'b0;
    pc = 32'h180;
    for (int i = 0; i < 8; i++) begin
      y = (i == 7) ? 5'd1 : 5'd16 - 5'(2 * i);
      put(ow(6'h20 + 6'(i % 6), {18'h0, y[3:0] - 4'h1, xl[i][3:0] - 4'h1}));
      // pitch and clip word, already adjusted by the list builder
      put(32'hC000_0000 | i);
      want(RGESEQ_K_EXP, (i % 6) / 2, (i % 2) ? 8'h3C : 8'h96, xl[i], y,
           32'hC000_0000 | i, M_EXP);
    end
    put(ow(RGESEQ_EXP_F_D, 26'h04));
    put(ow(RGESEQ_STOP, 26'h0));
    put(ow(RGESEQ_STOP, 26'h0));
    run(32'h180);
    check("bad factor", bad, 1'b1);
    judge("expand");
  endtask
  task automatic t_runs();
    logic [15:0] rl [3] = '{16'h0003, 16'h0007, 16'hFFFF};
    lat = 4'h2;
    stall = 1'b1;
    pc = 32'h300;
    foreach (rl[j]) put({16'h0, rl[j]});
    put(32'h0000_0000);
    pc = 32'h340;
    put(ow(RGESEQ_LOAD_HD, 26'h81));
    for (int i = 0; i < 6; i++) begin
      put(ow(6'h30 + i[5:0], 26'h0));
      put(32'h0000_0300);
      foreach (rl[j]) want(RGESEQ_K_RUN, i / 2, (i % 2) ? 8'h81 : 8'h5A, 5'h00, 5'h00,
                           {16'h0, rl[j]}, M_RUN);
    end
    put(ow(RGESEQ_RECT_F_SD, 26'h0));
    want(RGESEQ_K_RECT, 3'h0, 8'h96, 5'h00, 5'h00, 32'h0, M_RECT);
    put(ow(RGESEQ_STOP, 26'h0));
    run(32'h340);
    check("bad cleared", bad, 1'b0);
    judge("runs");
  endtask
  task automatic t_jump();
    int r;
    lat = 4'h1;
    stall = 1'b0;
    pc = 32'h200;
    put(ow(RGESEQ_LOAD_D, 26'h24));
    put(ow(RGESEQ_JUMP, 26'h0));
    put(32'h0000_0280);
    put(ow(RGESEQ_RECT_F_D, 26'h0));
    pc = 32'h280;
    put(ow(RGESEQ_RECT_U_D, 26'h0));
    want(RGESEQ_K_RECT, 3'h1, 8'h24, 5'h00, 5'h00, 32'h0, M_RECT);
    put(ow(RGESEQ_STOP, 26'h0));
    run(32'h200);
    r = reqn;
    repeat (20) @(negedge clk);
    check("fetches after stop", reqn, r);
    check("busy after stop", busy, 1'b0);
    judge("jump");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    check("idle", {busy, done, bad, mem_req, job_valid}, 5'h00);
    check("bitmaps", {bm_b, bm_u}, 64'h0);
    check("bitmaps", {bm_s, bm_h}, 64'h0);
    t_rect();
    t_exp();
    t_runs();
    t_jump();
    results();
  end
endmodule // test_graphic_order_sequencer
